// file: hdl/mcs_pkg.sv
/*
 * Package for the monitor configuration and limit status registers:
 * offsets, field positions, reset values, default limits, timing counts
 * and the power-up state type.
 * Assumes 8-bit registers on an 8-bit address space and a 250 MHz clock.
 */
package mcs_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int MCS_DW  = 8;
   localparam int MCS_AW  = 8;
   localparam int MCS_NCH = 7;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] MCS_OFS_CONFIG     = 8'h40;
   localparam logic [7:0] MCS_OFS_STATUS     = 8'h41;
   localparam logic [7:0] MCS_OFS_IRQ_STATUS = 8'h3e;
   localparam logic [7:0] MCS_OFS_IRQ_MASK   = 8'h3f;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] MCS_CONFIG_RESET   = 8'h00;
   localparam logic [7:0] MCS_STATUS_RESET   = 8'h00;
   localparam logic [7:0] MCS_IRQ_RESET      = 8'h00;

   // ---------------------------------------------------------------
   // monitor_configuration fields
   // ---------------------------------------------------------------
   localparam int MCS_CFG_START      = 0;
   localparam int MCS_CFG_LOCK       = 1;
   localparam int MCS_CFG_READY      = 2;
   localparam int MCS_CFG_FULL_SPEED = 3;
   localparam int MCS_CFG_POWER_CALC = 4;
   localparam int MCS_CFG_SPINUP_DIS = 5;
   localparam int MCS_CFG_TIMEOUT_DIS = 6;
   localparam int MCS_CFG_SUPPLY_5V  = 7;
   // start, power calc, timeout disable, supply scale
   localparam logic [7:0] MCS_CFG_LOCKABLE = 8'hd1;
   // full speed and spin-up pulse disable stay writable
   localparam logic [7:0] MCS_CFG_FREE     = 8'h28;

   // ---------------------------------------------------------------
   // limit_status_first / interrupt fields
   // ---------------------------------------------------------------
   localparam int MCS_ST_SUMMARY  = 7;
   localparam int MCS_IRQ_READY   = 7;

   // ---------------------------------------------------------------
   // channels and power-up default limits
   // ---------------------------------------------------------------
   // channels 4..6 are two's complement temperatures
   localparam logic [6:0] MCS_CH_SIGNED     = 7'h70;
   localparam logic [7:0] MCS_VOLT_LOW_DEF  = 8'h00;
   localparam logic [7:0] MCS_VOLT_HIGH_DEF = 8'hff;
   localparam logic [7:0] MCS_TEMP_LOW_DEF  = 8'h81;
   localparam logic [7:0] MCS_TEMP_HIGH_DEF = 8'h7f;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int MCS_CLK_FREQ_MHZ = 250;
   localparam int MCS_PWRUP_TIME_NS = 1000;
   localparam int MCS_PWRUP_CYCLES =
      (MCS_PWRUP_TIME_NS * MCS_CLK_FREQ_MHZ + 999) / 1000;

   typedef enum logic [0:0] {
      MCS_PWR_WAIT,
      MCS_PWR_READY
   } mcs_pwr_state_type;

endpackage

// file: hdl/mcs_cmp_if.sv
/*
 * Carrier between the register block and the limit comparator:
 * readings, programmed limits, limit select and violation flags.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface mcs_cmp_if #(
   parameter int NCH = 7,
   parameter int DW  = 8
);
   logic [NCH-1:0][DW-1:0] reading;
   logic [NCH-1:0][DW-1:0] prog_low;
   logic [NCH-1:0][DW-1:0] prog_high;
   logic                   use_prog;
   logic [NCH-1:0]         violation;

   modport regs (
      output reading,
      output prog_low,
      output prog_high,
      output use_prog,
      input  violation
   );

   modport cmp (
      input  reading,
      input  prog_low,
      input  prog_high,
      input  use_prog,
      output violation
   );
endinterface

// file: hdl/mcs_limit_cmp.sv
/*
 * Per-channel window comparator, programmed or power-up default limits.
 * Assumes readings and limits are synchronous to clk.
 */
`timescale 1ns/1ps
module mcs_limit_cmp
   import mcs_pkg::*;
#(
   parameter int NCH = MCS_NCH
) (
   input wire logic   clk,
   input wire logic   rst_n,
   mcs_cmp_if.cmp     cmp
);

   logic [NCH-1:0] nxt_violation;
   logic [NCH-1:0] violation_ff;

   // ---------------------------------------------------------------
   // comparators
   // ---------------------------------------------------------------
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      wire logic       is_temp = MCS_CH_SIGNED[i];
      wire logic [7:0] def_lo  = is_temp ? MCS_TEMP_LOW_DEF
                                         : MCS_VOLT_LOW_DEF;
      wire logic [7:0] def_hi  = is_temp ? MCS_TEMP_HIGH_DEF
                                         : MCS_VOLT_HIGH_DEF;
      wire logic [7:0] lo = cmp.use_prog ? cmp.prog_low[i]  : def_lo;
      wire logic [7:0] hi = cmp.use_prog ? cmp.prog_high[i] : def_hi;
      wire logic       above = is_temp
         ? ($signed(cmp.reading[i]) > $signed(hi))
         : (cmp.reading[i] > hi);
      wire logic       below = is_temp
         ? ($signed(cmp.reading[i]) <= $signed(lo))
         : (cmp.reading[i] <= lo);
      assign nxt_violation[i] = above | below;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         violation_ff <= '0;
      end else begin
         violation_ff <= nxt_violation;
      end
   end

   assign cmp.violation = violation_ff;

endmodule // mcs_limit_cmp

// file: hdl/mcs_regs.sv
/*
 * Configuration and first limit-status registers of a hardware monitor
 * and fan controller, with a power-up ready timer, limit comparison and
 * a masked interrupt.
 * Assumes a register port master on clk, readings and limit registers
 * supplied by same-clock logic, and rst_n as the power-on reset.
 */
`timescale 1ns/1ps
module mcs_regs
   import mcs_pkg::*;
#(
   parameter int          NCH          = MCS_NCH,
   parameter logic [15:0] PWRUP_CYCLES = 16'(MCS_PWRUP_CYCLES)
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic [MCS_AW-1:0]      reg_addr,
   input  wire logic [MCS_DW-1:0]      reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output      logic [MCS_DW-1:0]      reg_rdata,
   input  wire logic [NCH-1:0][7:0]    reading,
   input  wire logic [NCH-1:0][7:0]    prog_low,
   input  wire logic [NCH-1:0][7:0]    prog_high,
   input  wire logic [7:0]             second_status_latched,
   output      logic                   monitor_enable,
   output      logic                   full_speed_force,
   output      logic                   spinup_pulse_disable,
   output      logic                   bus_timeout_disable,
   output      logic                   supply_scale_5v,
   output      logic                   power_calc_enable,
   output      logic                   limit_lock,
   output      logic                   device_ready,
   output      logic                   irq
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   mcs_cmp_if #(.NCH(NCH), .DW(MCS_DW)) cmp_bus ();

   logic [7:0]        config_ff;
   logic [7:0]        nxt_config;
   logic [6:0]        status_ff;
   logic [6:0]        nxt_status;
   logic [7:0]        irq_status_ff;
   logic [7:0]        nxt_irq_status;
   logic [7:0]        irq_mask_ff;
   logic [7:0]        nxt_irq_mask;
   logic [7:0]        rdata_ff;
   logic [7:0]        nxt_rdata;
   logic [15:0]       pwr_cnt_ff;
   logic [15:0]       nxt_pwr_cnt;
   mcs_pwr_state_type pwr_state_ff;
   mcs_pwr_state_type nxt_pwr_state;
   logic              ready_rise;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire logic hit_config   = (reg_addr == MCS_OFS_CONFIG);
   wire logic hit_status   = (reg_addr == MCS_OFS_STATUS);
   wire logic hit_irq_stat = (reg_addr == MCS_OFS_IRQ_STATUS);
   wire logic hit_irq_mask = (reg_addr == MCS_OFS_IRQ_MASK);

   wire logic wr_config    = reg_wr & hit_config;
   wire logic wr_irq_stat  = reg_wr & hit_irq_stat;
   wire logic wr_irq_mask  = reg_wr & hit_irq_mask;
   wire logic rd_status    = reg_rd & hit_status;

   // ---------------------------------------------------------------
   // power-up ready timer
   // ---------------------------------------------------------------
   wire logic pwr_done = (pwr_cnt_ff == (PWRUP_CYCLES - 16'h0001));

   always_comb begin
      nxt_pwr_state = pwr_state_ff;
      nxt_pwr_cnt   = pwr_cnt_ff;
      ready_rise    = 1'b0;
      case (pwr_state_ff)
         MCS_PWR_WAIT: begin
            nxt_pwr_cnt = pwr_cnt_ff + 16'h0001;
            if (pwr_done) begin
               nxt_pwr_state = MCS_PWR_READY;
               ready_rise    = 1'b1;
            end
         end
         MCS_PWR_READY: begin
            nxt_pwr_cnt = pwr_cnt_ff;
         end
         default: begin
            nxt_pwr_state = MCS_PWR_WAIT;
            nxt_pwr_cnt   = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pwr_state_ff <= MCS_PWR_WAIT;
         pwr_cnt_ff   <= 16'h0000;
      end else begin
         pwr_state_ff <= nxt_pwr_state;
         pwr_cnt_ff   <= nxt_pwr_cnt;
      end
   end

   wire logic ready = (pwr_state_ff == MCS_PWR_READY);

   // ---------------------------------------------------------------
   // monitor_configuration
   // ---------------------------------------------------------------
   wire logic locked = config_ff[MCS_CFG_LOCK];

   // lockable fields take writes only while unlocked
   wire logic [7:0] cfg_wr_mask =
      locked ? MCS_CFG_FREE : (MCS_CFG_LOCKABLE | MCS_CFG_FREE);

   // lock sets once and never clears before power-on reset
   wire logic lock_set = wr_config & reg_wdata[MCS_CFG_LOCK];

   always_comb begin
      nxt_config = config_ff;
      // masked-off bits keep their value, no error
      if (wr_config) begin
         nxt_config = (config_ff & ~cfg_wr_mask)
                    | (reg_wdata & cfg_wr_mask);
      end
      nxt_config[MCS_CFG_LOCK]  = locked | lock_set;
      // ready bit is hardware owned, writes ignored
      nxt_config[MCS_CFG_READY] = ready;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         config_ff <= MCS_CONFIG_RESET;
      end else begin
         config_ff <= nxt_config;
      end
   end

   // ---------------------------------------------------------------
   // limit comparison
   // ---------------------------------------------------------------
   assign cmp_bus.reading   = reading;
   assign cmp_bus.prog_low  = prog_low;
   assign cmp_bus.prog_high = prog_high;
   assign cmp_bus.use_prog  = config_ff[MCS_CFG_START];

   mcs_limit_cmp #(
      .NCH (NCH)
   ) u_cmp (
      .clk   (clk),
      .rst_n (rst_n),
      .cmp   (cmp_bus)
   );

   // no flags before the part is ready: readings are not yet valid
   wire logic [6:0] fault = cmp_bus.violation & {NCH{ready}};

   // ---------------------------------------------------------------
   // limit_status_first
   // ---------------------------------------------------------------
   // bits 0-3 voltage channels
   // a read keeps only bits whose fault still stands
   // a fault present in the read cycle wins over the clear
   assign nxt_status = rd_status ? fault : (status_ff | fault);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_ff <= MCS_STATUS_RESET[6:0];
      end else begin
         status_ff <= nxt_status;
      end
   end

   // summary follows the second register continuously
   wire logic       summary   = |second_status_latched;
   wire logic [7:0] status_rd = {summary, status_ff};

   // ---------------------------------------------------------------
   // interrupt status and mask
   // ---------------------------------------------------------------
   // new flags, and the ready rise, are the events
   wire logic [6:0] new_flag = fault & ~status_ff;
   wire logic [7:0] irq_ev   = {ready_rise, new_flag};
   wire logic [7:0] irq_clr  = wr_irq_stat ? reg_wdata : 8'h00;

   // set wins over a write-one clear in the same cycle
   assign nxt_irq_status = (irq_status_ff & ~irq_clr) | irq_ev;
   assign nxt_irq_mask   = wr_irq_mask ? reg_wdata : irq_mask_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_status_ff <= MCS_IRQ_RESET;
         irq_mask_ff   <= MCS_IRQ_RESET;
      end else begin
         irq_status_ff <= nxt_irq_status;
         irq_mask_ff   <= nxt_irq_mask;
      end
   end

   // mask bit one lets the event through
   assign irq = |(irq_status_ff & irq_mask_ff);

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   // snapshot is taken from the pre-clear value of the status bits
   always_comb begin
      nxt_rdata = 8'h00;
      if (reg_rd) begin
         if (hit_config) begin
            nxt_rdata = config_ff;
         end else if (hit_status) begin
            nxt_rdata = status_rd;
         end else if (hit_irq_stat) begin
            nxt_rdata = irq_status_ff;
         end else if (hit_irq_mask) begin
            nxt_rdata = irq_mask_ff;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // ---------------------------------------------------------------
   // control outputs
   // ---------------------------------------------------------------
   // runs only when started and the ready bit already reads one
   assign monitor_enable       = config_ff[MCS_CFG_START]
                               & config_ff[MCS_CFG_READY];
   assign full_speed_force     = config_ff[MCS_CFG_FULL_SPEED];
   // spin-up logic holds PWM high for whole timeout
   assign spinup_pulse_disable = config_ff[MCS_CFG_SPINUP_DIS];
   assign bus_timeout_disable  = config_ff[MCS_CFG_TIMEOUT_DIS];
   // supply input scaled for 5.0 V when set, else 3.3 V
   assign supply_scale_5v      = config_ff[MCS_CFG_SUPPLY_5V];
   // power-calc flag held and locked like start, timeout disable and supply scale
   assign power_calc_enable    = config_ff[MCS_CFG_POWER_CALC];
   assign limit_lock           = locked;
   assign device_ready         = config_ff[MCS_CFG_READY];

endmodule // mcs_regs

// file: tb/mcs_regs_sva.sv
/*
 * Checker for the configuration and limit status register block.
 * Assumes only the top ports are visible, one clock, rst_n sync low.
 */
`timescale 1ns/1ps
module mcs_regs_sva
   import mcs_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [MCS_AW-1:0] reg_addr,
   input wire logic [MCS_DW-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [MCS_DW-1:0] reg_rdata,
   input wire logic [7:0]        second_status_latched,
   input wire logic              monitor_enable,
   input wire logic              full_speed_force,
   input wire logic              spinup_pulse_disable,
   input wire logic              bus_timeout_disable,
   input wire logic              supply_scale_5v,
   input wire logic              power_calc_enable,
   input wire logic              limit_lock,
   input wire logic              device_ready,
   input wire logic              irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire cfg_wr = reg_wr && reg_addr == MCS_OFS_CONFIG;
   wire st_rd  = reg_rd && reg_addr == MCS_OFS_STATUS;

   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   AST_START_WR: assert property (cfg_wr && !limit_lock && device_ready
      |=> monitor_enable == $past(reg_wdata[0]))
      else $error("start bit write not reflected");
   AST_START_READY: assert property (monitor_enable |-> device_ready)
      else $error("monitoring enabled before ready");
   AST_LOCK_START: assert property (limit_lock && device_ready
      |=> $stable(monitor_enable))
      else $error("start bit changed while locked");
   AST_LOCK_STICKY: assert property (limit_lock |=> limit_lock)
      else $error("lock bit cleared");
   AST_LOCKED_BITS: assert property (limit_lock |=> $stable(
      {power_calc_enable, bus_timeout_disable, supply_scale_5v}))
      else $error("lockable field changed while locked");
   AST_FULL_SPEED: assert property (cfg_wr
      |=> full_speed_force == $past(reg_wdata[3]))
      else $error("full speed bit write not reflected");
   AST_SPINUP: assert property (cfg_wr
      |=> spinup_pulse_disable == $past(reg_wdata[5]))
      else $error("spin-up bit write not reflected");
   AST_NO_WR_HOLD: assert property (!cfg_wr |=> $stable(
      {full_speed_force, spinup_pulse_disable, limit_lock}))
      else $error("config field changed without a write");
   AST_SUMMARY: assert property (st_rd
      |=> reg_rdata[MCS_ST_SUMMARY] == |$past(second_status_latched))
      else $error("summary bit wrong");
   AST_READY_HOLD: assert property (device_ready |=> device_ready)
      else $error("ready bit fell");

   cover property (cfg_wr && limit_lock);
   cover property (st_rd ##1 reg_rdata != 8'h00);
   cover property (irq);
endmodule // mcs_regs_sva

bind mcs_regs mcs_regs_sva mcs_regs_sva_i (.clk, .rst_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .second_status_latched,
   .monitor_enable, .full_speed_force, .spinup_pulse_disable,
   .bus_timeout_disable, .supply_scale_5v, .power_calc_enable,
   .limit_lock, .device_ready, .irq);

// file: tb/mcs_sense_model.sv
/*
 * Sense side model: channel readings and fixed programmed limits.
 * Assumes the register block samples them on the same clk.
 */
`timescale 1ns/1ps
module mcs_sense_model
   import mcs_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    load,
   input  wire logic [2:0]              sel,
   input  wire logic [7:0]              val,
   output      logic [MCS_NCH-1:0][7:0] reading,
   output      logic [MCS_NCH-1:0][7:0] prog_low,
   output      logic [MCS_NCH-1:0][7:0] prog_high
);
   always_comb begin
      for (int i = 0; i < MCS_NCH; i++) begin
         prog_low[i]  = (i > 3) ? 8'hf0 : 8'h40;
         prog_high[i] = (i > 3) ? 8'h30 : 8'h60;
      end
   end
   // nominal readings sit inside every limit pair
   initial begin
      for (int i = 0; i < MCS_NCH; i++) begin
         reading[i] = (i > 3) ? 8'h10 : 8'h50;
      end
   end
   always @(posedge clk) begin
      if (load) begin
         reading[sel] <= val;
      end
   end
endmodule // mcs_sense_model

// file: tb/tb_mcs_regs.sv
/*
 * Testbench for the monitor configuration and limit status registers.
 * Assumes the sense model drives readings and limits on the same clock.
 */
`timescale 1ns/1ps
module tb_mcs_regs
   import mcs_pkg::*;
;
   logic                    clk = 1'b0;
   logic                    rst_n = 1'b0;
   logic                    reg_wr = 1'b0;
   logic                    reg_rd = 1'b0;
   logic                    load = 1'b0;
   logic [7:0]              reg_addr = 8'h00;
   logic [7:0]              reg_wdata = 8'h00;
   logic [7:0]              sec_status = 8'h00;
   logic [7:0]              val = 8'h00;
   logic [2:0]              sel = 3'h0;
   logic [7:0]              reg_rdata;
   logic [MCS_NCH-1:0][7:0] reading, prog_low, prog_high;
   logic [7:0]              cfg_out;
   logic                    irq, pe;
   int                      err_total = 0;
   int                      checked = 0;
   logic [7:0]              tv [4] = '{8'h60, 8'h61, 8'h41, 8'h40};
   logic                    te [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

   initial forever #2 clk = ~clk;

   mcs_sense_model mcs_sense_model_i (.clk(clk), .load(load), .sel(sel),
      .val(val), .reading(reading), .prog_low(prog_low),
      .prog_high(prog_high));

   mcs_regs #(.PWRUP_CYCLES(16'd4)) mcs_regs_i (.clk(clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reading(reading),
      .prog_low(prog_low), .prog_high(prog_high),
      .second_status_latched(sec_status),
      .monitor_enable(cfg_out[0]), .limit_lock(cfg_out[1]),
      .device_ready(cfg_out[2]), .full_speed_force(cfg_out[3]),
      .power_calc_enable(cfg_out[4]), .spinup_pulse_disable(cfg_out[5]),
      .bus_timeout_disable(cfg_out[6]), .supply_scale_5v(cfg_out[7]),
      .irq(irq));

   // -------------------------------------------------------------
   // access tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   // comparator path takes two edges; one spare
   task automatic setv(input logic [2:0] ch, input logic [7:0] v);
      @(posedge clk);
      load <= 1'b1;
      sel <= ch;
      val <= v;
      @(posedge clk);
      load <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task automatic results();
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial begin
      reset();
      rd(MCS_OFS_CONFIG, 8'h00);
      for (int i = 0; i < 20 && cfg_out[2] !== 1'b1; i++) @(posedge clk);
      rd(MCS_OFS_CONFIG, 8'h04);
      rd(MCS_OFS_IRQ_STATUS, 8'h80);
      $display("test reset done");
      wr(8'h00, 8'hff);
      rd(8'h00, 8'h00);
      wr(MCS_OFS_STATUS, 8'hff);
      rd(MCS_OFS_STATUS, 8'h00);
      $display("test refused done");
      wr(MCS_OFS_CONFIG, 8'hf9);
      rd(MCS_OFS_CONFIG, 8'hfd);
      chk(cfg_out, 8'hfd);
      wr(MCS_OFS_CONFIG, 8'h00);
      rd(MCS_OFS_CONFIG, 8'h04);
      chk(cfg_out, 8'h04);
      $display("test config done");
      // default limits: reading at the low limit counts as a fault
      for (int c = 0; c < MCS_NCH; c++) begin
         setv(3'(c), (c > 3) ? 8'h81 : 8'h00);
         rd(MCS_OFS_STATUS, 8'h01 << c);
         rd(MCS_OFS_STATUS, 8'h01 << c);
         setv(3'(c), (c > 3) ? 8'h10 : 8'h50);
         rd(MCS_OFS_STATUS, 8'h01 << c);
         rd(MCS_OFS_STATUS, 8'h00);
      end
      setv(3'd0, 8'h61);
      rd(MCS_OFS_STATUS, 8'h00);
      $display("test status done");
      rd(MCS_OFS_IRQ_STATUS, 8'hff);
      chk({7'h0, irq}, 8'h00);
      wr(MCS_OFS_IRQ_MASK, 8'h01);
      chk({7'h0, irq}, 8'h01);
      wr(MCS_OFS_IRQ_STATUS, 8'hff);
      rd(MCS_OFS_IRQ_STATUS, 8'h00);
      chk({7'h0, irq}, 8'h00);
      @(posedge clk);
      sec_status <= 8'h10;
      rd(MCS_OFS_STATUS, 8'h80);
      @(posedge clk);
      sec_status <= 8'h00;
      rd(MCS_OFS_STATUS, 8'h00);
      $display("test irq done");
      wr(MCS_OFS_CONFIG, 8'h01);
      // ch0 still holds 0x61, above the programmed high once started
      pe = 1'b1;
      foreach (tv[i]) begin
         setv(3'd0, tv[i]);
         rd(MCS_OFS_STATUS, {7'h0, te[i] | pe});
         rd(MCS_OFS_STATUS, {7'h0, te[i]});
         pe = te[i];
      end
      $display("test limits done");
      wr(MCS_OFS_CONFIG, 8'h03);
      rd(MCS_OFS_CONFIG, 8'h07);
      wr(MCS_OFS_CONFIG, 8'hf8);
      rd(MCS_OFS_CONFIG, 8'h2f);
      wr(MCS_OFS_CONFIG, 8'h00);
      rd(MCS_OFS_CONFIG, 8'h07);
      chk(cfg_out, 8'h07);
      reset();
      rd(MCS_OFS_CONFIG, 8'h00);
      $display("test lock done");
      results();
   end

   // hang guard, well past the few hundred cycles of the tests
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      results();
   end
endmodule // tb_mcs_regs
